// ==== src/dma_engine.sv ====
/*
  Two-channel cycle-steal transfer engine with an AXI4-Lite register port.
  Assumes a memory bus that answers each request with a one-cycle ack and
  that grants this engine priority over the processor while mem_req is high.
  Peripheral event lines are one-cycle pulses synchronous to aclk.
*/
// The implementer's own choices: the address map and the AXI4-Lite register port.
`timescale 1ns/10ps
`default_nettype none

// How it works
// - two independent channels share one bus
// - one 8/16-bit unit per accepted request
// - engine bus request overrides the processor
// - software bit or selected event requests
// - processor interrupt masks never gate requests
// - source interrupt flags are never touched
// - enabled channel transfers once per request
// - fast repeated requests merge into one
// - 20-bit pointers, never both incrementing
// - 16-bit counter gives 64K units
// - channel 0 wins over channel 1
// - single mode ends on counter underflow
// - repeat mode reloads counter on underflow
// - underflow pulses the channel's done irq
// - single stops on underflow/disable, repeat on disable
// - first transfer loads pointer and counter
// - pin, timer, serial, analog, software sources
// - 4-bit code plus extended set decode
// - pending flag clears on 0, ignores 1
// - rewriting enable repeats the reload
module dma_engine
  import dma_pkg::*;
(
  // clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        clk_en,
  // axi4-lite slave
  input  wire logic [7:0]  s_awaddr,
  input  wire logic        s_awvalid,
  output logic             s_awready,
  input  wire logic [31:0] s_wdata,
  input  wire logic [3:0]  s_wstrb,
  input  wire logic        s_wvalid,
  output logic             s_wready,
  output logic [1:0]       s_bresp,
  output logic             s_bvalid,
  input  wire logic        s_bready,
  input  wire logic [7:0]  s_araddr,
  input  wire logic        s_arvalid,
  output logic             s_arready,
  output logic [31:0]      s_rdata,
  output logic [1:0]       s_rresp,
  output logic             s_rvalid,
  input  wire logic        s_rready,
  // request sources: [0] ext_irq0 edges, [1] ext_irq1 edges
  input  wire logic [1:0]  ext_irq,
  input  wire logic [15:0] periph_event,  // pulses, indexed by code
  // shared memory bus
  output mem_req_type      mem_req,
  input  wire mem_rsp_type mem_rsp,
  output logic             bus_steal,
  // completion interrupt pulses
  output logic [1:0]       done_irq
);

  // ----------------------------------------------------------------------
  // per-channel registers
  // ----------------------------------------------------------------------
  logic [7:0]         sel_q   [NUM_CH];
  logic [5:0]         ctl_q   [NUM_CH];
  logic [ADDR_W-1:0]  src_q   [NUM_CH];
  logic [ADDR_W-1:0]  dst_q   [NUM_CH];
  logic [COUNT_W-1:0] rld_q   [NUM_CH];
  logic [COUNT_W-1:0] cnt_q   [NUM_CH];
  logic [ADDR_W-1:0]  fwd_q   [NUM_CH];
  logic               fresh_q [NUM_CH];  // reload pending at next start
  logic               uflow_q [NUM_CH];
  logic [1:0]         pin_q;
  logic [1:0]         trig;
  logic [1:0]         sw_set;
  logic [1:0]         en_wr;

  // bus handshake state
  logic       aw_q, w_q, ar_q;
  logic [7:0] awaddr_q;
  logic [31:0] wdata_q;
  logic       wr_fire;
  logic       grp_ok_w, grp_ok_r;
  logic [4:0] woff, roff;
  logic       wch, rch;

  // transfer engine
  xfer_state_type state_q;
  logic           cur_q;
  logic [15:0]    data_q;
  logic [1:0]     want;
  logic           pick;
  logic [ADDR_W-1:0] rd_addr, wr_addr, step;

  // ----------------------------------------------------------------------
  // axi4-lite write path: address and data taken in either order
  // ----------------------------------------------------------------------
  assign s_awready = !aw_q && !s_bvalid;
  assign s_wready  = !w_q && !s_bvalid;
  assign wr_fire   = aw_q && w_q && !s_bvalid;
  assign woff      = awaddr_q[4:0];
  assign wch       = awaddr_q[5];
  assign grp_ok_w  = (awaddr_q[7:6] == 2'h0) && (awaddr_q[1:0] == 2'h0);

  // write channel capture and response
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_q     <= 1'b0;
      w_q      <= 1'b0;
      awaddr_q <= 8'h00;
      wdata_q  <= 32'h0000_0000;
      s_bvalid <= 1'b0;
      s_bresp  <= RESP_OKAY;
    end
    else if (clk_en)
    begin
      if (s_awvalid && s_awready)
      begin
        aw_q     <= 1'b1;
        awaddr_q <= s_awaddr;
      end
      if (s_wvalid && s_wready)
      begin
        w_q     <= 1'b1;
        wdata_q <= s_wdata;
      end
      if (wr_fire)
      begin
        aw_q     <= 1'b0;
        w_q      <= 1'b0;
        s_bvalid <= 1'b1;
        s_bresp  <= grp_ok_w ? RESP_OKAY : RESP_SLVERR;
      end
      else if (s_bvalid && s_bready)
        s_bvalid <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // axi4-lite read path, one cycle after the address
  // ----------------------------------------------------------------------
  assign s_arready = !s_rvalid;
  assign roff      = s_araddr[4:0];
  assign rch       = s_araddr[5];
  assign grp_ok_r  = (s_araddr[7:6] == 2'h0) && (s_araddr[1:0] == 2'h0);

  // read data mux
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_rvalid <= 1'b0;
      s_rdata  <= 32'h0000_0000;
      s_rresp  <= RESP_OKAY;
    end
    else if (clk_en)
    begin
      if (s_arvalid && s_arready)
      begin
        s_rvalid <= 1'b1;
        s_rresp  <= grp_ok_r ? RESP_OKAY : RESP_SLVERR;
        case (roff)
          OFF_REQUEST_SELECT: s_rdata <= {24'h000000, sel_q[rch]};
          OFF_CHANNEL_CTRL:   s_rdata <= {26'h0000000, ctl_q[rch]};
          OFF_SOURCE_PTR:     s_rdata <= {12'h000, src_q[rch]};
          OFF_DEST_PTR:       s_rdata <= {12'h000, dst_q[rch]};
          OFF_RELOAD:         s_rdata <= {16'h0000, rld_q[rch]};
          OFF_COUNT:          s_rdata <= {16'h0000, cnt_q[rch]};
          OFF_ACTIVE_PTR:     s_rdata <= {12'h000, fwd_q[rch]};
          OFF_STATUS:         s_rdata <= {31'h00000000, uflow_q[rch]};
          default:            s_rdata <= 32'h0000_0000;
        endcase
        if (!grp_ok_r)
          s_rdata <= 32'h0000_0000;
      end
      else if (s_rvalid && s_rready)
        s_rvalid <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // request decode per channel
  // ----------------------------------------------------------------------
  // pin history for edge detection
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      pin_q <= 2'h3;
    else if (clk_en)
      pin_q <= ext_irq;
  end

  // software trigger and enable write strobes
  always_comb
  begin
    for (int c = 0; c < NUM_CH; c++)
    begin
      sw_set[c] = wr_fire && grp_ok_w && (wch == c[0]) && s_wstrb[0]
                  && (woff == OFF_REQUEST_SELECT)
                  && wdata_q[SEL_SWREQ_BIT] && !wdata_q[SEL_EXT_BIT]
                  && (wdata_q[SEL_CODE_LSB +: 4] == CODE_SOFTWARE);
      en_wr[c]  = wr_fire && grp_ok_w && (wch == c[0]) && s_wstrb[0]
                  && (woff == OFF_CHANNEL_CTRL)
                  && wdata_q[CTL_ENABLE_BIT];
    end
  end

  // event selection; interrupt masks play no part
  always_comb
  begin
    logic [3:0] code;
    logic       ext;
    logic       fall, both;
    code = 4'h0;
    ext  = 1'b0;
    fall = 1'b0;
    both = 1'b0;
    for (int c = 0; c < NUM_CH; c++)
    begin
      code = sel_q[c][SEL_CODE_LSB +: 4];
      ext  = sel_q[c][SEL_EXT_BIT];
      fall = pin_q[c] && !ext_irq[c];
      both = pin_q[c] != ext_irq[c];
      // the write's own code decides, so select and trigger may share a write
      if (sw_set[c])
        trig[c] = 1'b1;
      else if (!ext)
        trig[c] = (code == CODE_PIN_EDGE) ? fall :
                  (code == CODE_SOFTWARE) ? 1'b0 :
                  periph_event[code];
      else
        trig[c] = (code == (c == 0 ? CODE_CH0_BOTH : CODE_CH1_BOTH))
                  && both;
    end
  end

  // ----------------------------------------------------------------------
  // channel arbitration and transfer sequencing
  // ----------------------------------------------------------------------
  always_comb
  begin
    for (int c = 0; c < NUM_CH; c++)
      want[c] = ctl_q[c][CTL_PEND_BIT] && ctl_q[c][CTL_ENABLE_BIT];
  end
  assign pick = !want[0];
  assign step = ctl_q[cur_q][CTL_UNIT8_BIT] ? STEP_BYTE : STEP_WORD;
  assign rd_addr = (ctl_q[cur_q][CTL_SRC_DIR] && !fresh_q[cur_q])
                   ? fwd_q[cur_q] : src_q[cur_q];
  assign wr_addr = (ctl_q[cur_q][CTL_DEST_DIR] && !fresh_q[cur_q]
                   && !ctl_q[cur_q][CTL_SRC_DIR])
                   ? fwd_q[cur_q] : dst_q[cur_q];

  // bus request drive; high means processor is held off
  always_comb
  begin
    mem_req           = '0;
    mem_req.req       = (state_q != ST_IDLE);
    mem_req.write     = (state_q == ST_WRITE);
    mem_req.byte_unit = ctl_q[cur_q][CTL_UNIT8_BIT];
    mem_req.addr      = (state_q == ST_WRITE) ? wr_addr : rd_addr;
    mem_req.wdata     = data_q;
  end
  assign bus_steal = mem_req.req;

  // read-then-write sequencer, one unit per grant
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state_q <= ST_IDLE;
      cur_q   <= 1'b0;
      data_q  <= 16'h0000;
    end
    else if (clk_en)
    begin
      case (state_q)
        ST_IDLE:
          if (|want)
          begin
            cur_q   <= pick;
            state_q <= ST_READ;
          end
        ST_READ:
          if (mem_rsp.ack)
          begin
            data_q  <= mem_rsp.rdata;
            state_q <= ST_WRITE;
          end
        ST_WRITE:
          if (mem_rsp.ack)
            state_q <= ST_IDLE;
        default:
          state_q <= ST_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // channel state: registers, pointers, counters
  // ----------------------------------------------------------------------
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      done_irq <= 2'h0;
      for (int c = 0; c < NUM_CH; c++)
      begin
        sel_q[c]   <= 8'h00;
        ctl_q[c]   <= 6'h00;
        src_q[c]   <= 20'h00000;
        dst_q[c]   <= 20'h00000;
        rld_q[c]   <= 16'h0000;
        cnt_q[c]   <= 16'h0000;
        fwd_q[c]   <= 20'h00000;
        fresh_q[c] <= 1'b0;
        uflow_q[c] <= 1'b0;
      end
    end
    else if (clk_en)
    begin
      done_irq <= 2'h0;
      for (int c = 0; c < NUM_CH; c++)
      begin
        // software writes
        if (wr_fire && grp_ok_w && wch == c[0] && s_wstrb[0])
        begin
          case (woff)
            OFF_REQUEST_SELECT: sel_q[c] <= {1'b0, 1'b0,
              wdata_q[SEL_EXT_BIT], 1'b0, wdata_q[3:0]};
            OFF_CHANNEL_CTRL:
            begin
              ctl_q[c] <= {wdata_q[CTL_SRC_DIR] & !wdata_q[CTL_DEST_DIR],
                           wdata_q[CTL_DEST_DIR], wdata_q[CTL_ENABLE_BIT],
                           ctl_q[c][CTL_PEND_BIT] & wdata_q[CTL_PEND_BIT],
                           wdata_q[1:0]};
              if (en_wr[c])
                fresh_q[c] <= 1'b1;
            end
            OFF_SOURCE_PTR: src_q[c] <= wdata_q[ADDR_W-1:0];
            OFF_DEST_PTR:   dst_q[c] <= wdata_q[ADDR_W-1:0];
            OFF_RELOAD:     rld_q[c] <= wdata_q[COUNT_W-1:0];
            OFF_STATUS:
              if (wdata_q[STAT_UFLOW_BIT])
                uflow_q[c] <= 1'b0;
            default: ;
          endcase
        end
        // pending cleared when the transfer starts
        if (state_q == ST_IDLE && |want && pick == c[0])
          ctl_q[c][CTL_PEND_BIT] <= 1'b0;
        // a new request sets pending, winning over any clear
        if (trig[c])
          ctl_q[c][CTL_PEND_BIT] <= 1'b1;
        // unit finished: advance counter and pointer
        if (state_q == ST_WRITE && mem_rsp.ack && cur_q == c[0])
        begin
          fresh_q[c] <= 1'b0;
          if (ctl_q[c][CTL_SRC_DIR] || ctl_q[c][CTL_DEST_DIR])
            fwd_q[c] <= (fresh_q[c] ? (ctl_q[c][CTL_SRC_DIR]
                         ? src_q[c] : dst_q[c]) : fwd_q[c]) + step;
          if ((fresh_q[c] ? rld_q[c] : cnt_q[c]) == 16'h0000)
          begin
            done_irq[c] <= 1'b1;
            uflow_q[c]  <= 1'b1;
            cnt_q[c]    <= rld_q[c];
            fresh_q[c]  <= ctl_q[c][CTL_REPEAT_BIT];
            if (!ctl_q[c][CTL_REPEAT_BIT])
              ctl_q[c][CTL_ENABLE_BIT] <= 1'b0;
          end
          else
            cnt_q[c] <= (fresh_q[c] ? rld_q[c] : cnt_q[c]) - 16'h0001;
        end
      end
    end
  end

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  prio_zero_a: assert property (@(posedge aclk) disable iff (!aresetn)
    clk_en && state_q == ST_IDLE && want[0] |=> !cur_q)
    else $error("channel 1 served ahead of channel 0");
  steal_a: assert property (@(posedge aclk) disable iff (!aresetn)
    state_q != ST_IDLE |-> bus_steal)
    else $error("transfer without bus priority");
  idle_req_a: assert property (@(posedge aclk) disable iff (!aresetn)
    state_q == ST_IDLE |-> !mem_req.req)
    else $error("bus request while idle");
  single_stop_a: assert property (@(posedge aclk) disable iff (!aresetn)
    clk_en && done_irq[0] == 1'b0 && state_q == ST_WRITE && mem_rsp.ack
    && !cur_q && !ctl_q[0][CTL_REPEAT_BIT] && !fresh_q[0]
    && cnt_q[0] == 16'h0000 && !en_wr[0]
    |=> !ctl_q[0][CTL_ENABLE_BIT] && done_irq[0])
    else $error("single mode did not stop on underflow");
  repeat_reload_a: assert property (@(posedge aclk) disable iff (!aresetn)
    clk_en && state_q == ST_WRITE && mem_rsp.ack && !cur_q
    && !fresh_q[0] && cnt_q[0] == 16'h0000
    |=> cnt_q[0] == $past(rld_q[0]))
    else $error("counter not reloaded on underflow");
  count_dec_a: assert property (@(posedge aclk) disable iff (!aresetn)
    clk_en && state_q == ST_WRITE && mem_rsp.ack && !cur_q
    && !fresh_q[0] && cnt_q[0] != 16'h0000
    |=> cnt_q[0] == $past(cnt_q[0]) - 16'h0001)
    else $error("counter not decremented");
  pend_set_a: assert property (@(posedge aclk) disable iff (!aresetn)
    clk_en && trig[1] |=> ctl_q[1][CTL_PEND_BIT])
    else $error("request lost");
  dir_excl_a: assert property (@(posedge aclk) disable iff (!aresetn)
    !(ctl_q[0][CTL_SRC_DIR] && ctl_q[0][CTL_DEST_DIR]))
    else $error("both pointers incrementing");
  xfer_done_a: assert property (@(posedge aclk) disable iff (!aresetn)
    state_q == ST_READ && mem_rsp.ack && clk_en ##1 state_q == ST_WRITE
    |-> mem_req.write)
    else $error("write phase missing");
  cov_both_c: cover property (@(posedge aclk) disable iff (!aresetn)
    state_q == ST_IDLE && want == 2'h3);
  cov_uflow_c: cover property (@(posedge aclk) disable iff (!aresetn)
    done_irq[1]);
  cov_repeat_c: cover property (@(posedge aclk) disable iff (!aresetn)
    done_irq[0] && ctl_q[0][CTL_REPEAT_BIT]);

endmodule : dma_engine

`default_nettype wire

// ==== src/dma_pkg.sv ====
/*
  Package for the two-channel cycle-steal transfer engine: register offsets,
  field positions, widths, request source codes and carrier structs.
  Assumes an AXI4-Lite master with 32-bit data and a shared memory bus that
  grants the engine priority over the processor.
*/
package dma_pkg;

  // ----------------------------------------------------------------------
  // register map, byte addresses, one word each, channel stride 0x20
  // ----------------------------------------------------------------------
  localparam logic [7:0] CH_STRIDE          = 8'h20;
  localparam logic [4:0] OFF_REQUEST_SELECT = 5'h00;
  localparam logic [4:0] OFF_CHANNEL_CTRL   = 5'h04;
  localparam logic [4:0] OFF_SOURCE_PTR     = 5'h08;
  localparam logic [4:0] OFF_DEST_PTR       = 5'h0C;
  localparam logic [4:0] OFF_RELOAD         = 5'h10;
  localparam logic [4:0] OFF_COUNT          = 5'h14;
  localparam logic [4:0] OFF_ACTIVE_PTR     = 5'h18;
  localparam logic [4:0] OFF_STATUS         = 5'h1C;

  // request_select_reg fields
  localparam int SEL_CODE_LSB  = 0;  // source_select_code [3:0]
  localparam int SEL_EXT_BIT   = 5;  // extended_source_select
  localparam int SEL_SWREQ_BIT = 6;  // software_request_bit

  // channel_control_reg fields
  localparam int CTL_UNIT8_BIT   = 0;  // 1 = byte units, 0 = 16-bit units
  localparam int CTL_REPEAT_BIT  = 1;  // 1 = repeat mode
  localparam int CTL_PEND_BIT    = 2;  // request_pending_flag
  localparam int CTL_ENABLE_BIT  = 3;  // channel_enable_bit
  localparam int CTL_DEST_DIR    = 4;  // dest_direction_bit
  localparam int CTL_SRC_DIR     = 5;  // source_direction_bit

  // status register: bit 0 underflow seen (write 1 clears)
  localparam int STAT_UFLOW_BIT = 0;

  localparam int  ADDR_W  = 20;  // 1M byte space
  localparam int  COUNT_W = 16;
  localparam int  NUM_CH  = 2;

  localparam logic [3:0] CODE_PIN_EDGE = 4'h0;
  localparam logic [3:0] CODE_SOFTWARE = 4'h1;
  localparam logic [3:0] CODE_CH0_BOTH = 4'h6;  // extended set, channel 0
  localparam logic [3:0] CODE_CH1_BOTH = 4'h7;  // extended set, channel 1

  localparam logic [ADDR_W-1:0] STEP_BYTE = 20'h00001;
  localparam logic [ADDR_W-1:0] STEP_WORD = 20'h00002;
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;

  // ----------------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic              req;
    logic              write;
    logic              byte_unit;
    logic [ADDR_W-1:0] addr;
    logic [15:0]       wdata;
  } mem_req_type;

  typedef struct packed {
    logic        ack;
    logic [15:0] rdata;
  } mem_rsp_type;

  typedef enum logic [1:0] {ST_IDLE, ST_READ, ST_WRITE} xfer_state_type;

endpackage : dma_pkg

// ==== verification/mem_model.sv ====
/*
  Behavioural memory on the engine's shared bus: one ack pulse per phase.
  Assumes one phase at a time; lat sets the wait before each ack.
*/
`timescale 1ns/10ps
`default_nettype none
module mem_model
  import dma_pkg::*;
(
  // clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // engine side
  input  wire mem_req_type mem_req,
  output mem_rsp_type      mem_rsp,
  // bench side
  input  wire logic [3:0]  lat,
  output logic [19:0]      wr_addr,
  output logic [15:0]      wr_data,
  output logic [7:0]       wr_cnt
);
  // ----------------------------------------------------------------
  // phase answer
  // ----------------------------------------------------------------
  logic [3:0] wait_q;
  // data lines flip outside acks so stale data never looks valid
  always_ff @(posedge aclk)
  begin
    mem_rsp.ack <= 1'b0;
    mem_rsp.rdata <= ~mem_rsp.rdata;
    wait_q <= 4'h0;
    if (!aresetn)
    begin
      wr_cnt <= 8'h00;
      mem_rsp.rdata <= 16'hC3C3;
    end
    else if (mem_req.req && !mem_rsp.ack && wait_q != lat)
      wait_q <= wait_q + 4'h1;  // slow answer
    else if (mem_req.req && !mem_rsp.ack)
    begin
      mem_rsp.ack <= 1'b1;
      mem_rsp.rdata <= mem_req.addr[15:0] ^ 16'h5A5A;
      if (mem_req.write)
      begin
        wr_addr <= mem_req.addr;
        wr_data <= mem_req.wdata;
        wr_cnt <= wr_cnt + 8'h01;
      end
    end
  end
endmodule : mem_model
`default_nettype wire

// ==== verification/two_channel_cycle_steal_dma_tb.sv ====
/*
  Self-checking bench for the transfer engine: register port, request
  sources, priority, modes. Assumes mem_model on the shared bus.
*/
`timescale 1ns/10ps
`default_nettype none
`define CHK(e, g) begin total_checks++; if ((g) !== (e)) begin \
  miscompares++; $display("[ERR] %0t mismatch %h", $time, g); end end
module two_channel_cycle_steal_dma_tb;
  import dma_pkg::*;
  // ----------------------------------------------------------------
  // signals and instances
  // ----------------------------------------------------------------
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] s_awaddr = 8'h00, s_araddr = 8'h00;
  logic [31:0] s_wdata = 32'h0, s_rdata;
  logic s_awvalid = 1'b0, s_wvalid = 1'b0, s_arvalid = 1'b0;
  logic s_awready, s_wready, s_bvalid, s_arready, s_rvalid;
  logic [1:0] s_bresp, s_rresp, done_irq, resp;
  logic [15:0] periph_event = 16'h0, wr_data;
  logic [3:0] lat = 4'h0;
  logic [1:0] ext_irq = 2'b11;
  logic [19:0] wr_addr;
  logic [7:0] wr_cnt, dn0 = 8'h0, dn1 = 8'h0;
  logic [31:0] rd;
  logic bus_steal;
  mem_req_type mem_req;
  mem_rsp_type mem_rsp;
  int miscompares = 0, total_checks = 0, cyc = 0;
  dma_engine dma_engine_i (.aclk(aclk), .aresetn(aresetn), .clk_en(1'b1),
    .s_awaddr(s_awaddr), .s_awvalid(s_awvalid), .s_awready(s_awready),
    .s_wdata(s_wdata), .s_wstrb(4'hF), .s_wvalid(s_wvalid),
    .s_wready(s_wready), .s_bresp(s_bresp), .s_bvalid(s_bvalid),
    .s_bready(1'b1), .s_araddr(s_araddr), .s_arvalid(s_arvalid),
    .s_arready(s_arready), .s_rdata(s_rdata), .s_rresp(s_rresp),
    .s_rvalid(s_rvalid), .s_rready(1'b1), .ext_irq(ext_irq),
    .periph_event(periph_event), .mem_req(mem_req), .mem_rsp(mem_rsp),
    .bus_steal(bus_steal), .done_irq(done_irq));
  mem_model mem_model_i (.aclk(aclk), .aresetn(aresetn), .mem_req(mem_req),
    .mem_rsp(mem_rsp), .lat(lat), .wr_addr(wr_addr), .wr_data(wr_data),
    .wr_cnt(wr_cnt));
  // clock, timeout and completion pulse counters
  always #2 aclk = ~aclk;
  always @(posedge aclk)
  begin
    cyc++;
    dn0 <= dn0 + {7'h0, done_irq[0] === 1'b1};
    dn1 <= dn1 + {7'h0, done_irq[1] === 1'b1};
    if (cyc == 20000)
    begin
      miscompares++;
      give_verdict();
    end
  end
  // ----------------------------------------------------------------
  // bus tasks
  // ----------------------------------------------------------------
  task automatic axw(input logic [7:0] a, input logic [31:0] d);
    logic aw_ok, w_ok;
    begin
      aw_ok = 1'b0;
      w_ok = 1'b0;
      s_awaddr <= a;
      s_wdata <= d;
      s_awvalid <= 1'b1;
      s_wvalid <= 1'b1;
      while (!(aw_ok && w_ok))
      begin
        @(posedge aclk);
        if (!aw_ok && s_awready === 1'b1) s_awvalid <= 1'b0;
        if (!aw_ok && s_awready === 1'b1) aw_ok = 1'b1;
        if (!w_ok && s_wready === 1'b1) s_wvalid <= 1'b0;
        if (!w_ok && s_wready === 1'b1) w_ok = 1'b1;
      end
      do @(posedge aclk); while (s_bvalid !== 1'b1);
      resp = s_bresp;
    end
  endtask : axw
  task automatic axr(input logic [7:0] a);
    begin
      s_araddr <= a;
      s_arvalid <= 1'b1;
      do @(posedge aclk); while (s_arready !== 1'b1);
      s_arvalid <= 1'b0;
      do @(posedge aclk); while (s_rvalid !== 1'b1);
      rd = s_rdata;
      resp = s_rresp;
    end
  endtask : axr
  task automatic wait_wr(input logic [7:0] n);
    int k;
    begin
      for (k = 0; k < 300 && wr_cnt !== n; k++) @(posedge aclk);
      `CHK(n, wr_cnt)
    end
  endtask : wait_wr
  task automatic pulse(input logic [15:0] ev);
    begin
      periph_event <= ev;
      @(posedge aclk);
      periph_event <= 16'h0;
      @(posedge aclk);
    end
  endtask : pulse
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  // reset values and refused addresses
  task automatic t_regs;
    begin
      axr(8'h04);
      `CHK(32'h0, rd)
      axr(8'h40);
      `CHK(RESP_SLVERR, resp)
      `CHK(32'h0, rd)
      axw(8'h82, 32'h1);
      `CHK(RESP_SLVERR, resp)
    end
  endtask : t_regs
  // software trigger, single mode, byte units, source forward
  task automatic t_single;
    begin
      axw(8'h08, 32'h01000);
      axw(8'h0C, 32'h02000);
      axw(8'h10, 32'h1);
      axw(8'h04, 32'h29);
      axr(8'h08);
      `CHK(32'h01000, rd)
      axw(8'h00, 32'h41);
      wait_wr(8'h01);
      `CHK(20'h02000, wr_addr)
      `CHK(8'h5A, wr_data[7:0])
      `CHK(8'h00, dn0)
      axw(8'h00, 32'h41);
      wait_wr(8'h02);
      `CHK(8'h5B, wr_data[7:0])
      repeat (3) @(posedge aclk);
      `CHK(8'h01, dn0)
      axw(8'h00, 32'h41);
      repeat (30) @(posedge aclk);
      `CHK(8'h02, wr_cnt)
    end
  endtask : t_single
  // one event on both channels, repeat mode, word units, slow memory
  task automatic t_repeat;
    begin
      lat <= 4'h3;
      axw(8'h08, 32'h05000);
      axw(8'h0C, 32'h06000);
      axw(8'h10, 32'h0);
      axw(8'h00, 32'h02);
      axw(8'h04, 32'h0A);
      axw(8'h28, 32'h03000);
      axw(8'h2C, 32'h04000);
      axw(8'h30, 32'h0);
      axw(8'h20, 32'h02);
      axw(8'h3A, 32'h1A);
      axw(8'h24, 32'h1A);
      pulse(16'h0004);
      wait_wr(8'h03);
      `CHK(20'h06000, wr_addr)
      `CHK(16'h0A5A, wr_data)
      wait_wr(8'h04);
      `CHK(20'h04000, wr_addr)
      pulse(16'h0004);
      wait_wr(8'h06);
      `CHK(20'h04000, wr_addr)
      `CHK(16'h6A5A, wr_data)
      axw(8'h24, 32'h1A);
      pulse(16'h0004);
      wait_wr(8'h08);
      `CHK(20'h04000, wr_addr)
      repeat (3) @(posedge aclk);
      `CHK(8'h03, dn1)
    end
  endtask : t_repeat
  // pending flag on a disabled channel
  task automatic t_pending;
    begin
      axw(8'h24, 32'h12);
      axw(8'h20, 32'h41);
      axr(8'h24);
      `CHK(1'b1, rd[CTL_PEND_BIT])
      axw(8'h24, 32'h16);
      axr(8'h24);
      `CHK(1'b1, rd[CTL_PEND_BIT])
      axw(8'h24, 32'h12);
      axr(8'h24);
      `CHK(1'b0, rd[CTL_PEND_BIT])
      `CHK(8'h08, wr_cnt)
    end
  endtask : t_pending
  // pin sources: falling edge on channel 0, both edges on channel 1
  task automatic t_pin;
    begin
      axw(8'h00, 32'h00);
      axw(8'h04, 32'h0B);
      ext_irq <= 2'b10;
      wait_wr(8'h09);
      `CHK(20'h06000, wr_addr)
      repeat (30) @(posedge aclk);
      ext_irq <= 2'b11;
      repeat (30) @(posedge aclk);
      `CHK(8'h09, wr_cnt)
      axw(8'h20, 32'h27);
      axw(8'h24, 32'h1A);
      ext_irq <= 2'b01;
      wait_wr(8'h0A);
      ext_irq <= 2'b11;
      wait_wr(8'h0B);
    end
  endtask : t_pin
  task automatic give_verdict;
    begin
      $display("checks %0d, mismatches %0d", total_checks, miscompares);
      if (miscompares == 0 && total_checks > 0)
        $display("All tests passed");
      else
        $display("Some tests failed");
      $finish;
    end
  endtask : give_verdict
  // main sequence
  initial
  begin
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_regs();
    t_single();
    t_repeat();
    t_pending();
    t_pin();
    give_verdict();
  end
endmodule : two_channel_cycle_steal_dma_tb
`default_nettype wire
